// ===== rtl/sms_pkg.sv
package sms_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned MS_NS          = 1000000;
    localparam int unsigned CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] MON_MS_RST     = 16'h0000;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MON    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int unsigned CTRL_ACT_BIT  = 0;
    localparam int unsigned CTRL_AUTO_BIT = 1;
    localparam int unsigned ST_ERR_BIT    = 16;
    localparam int unsigned ST_RDY_BIT    = 17;
    localparam int unsigned ST_ANY_BIT    = 18;
    localparam int unsigned ST_SEL_LSB    = 24;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Diagnostic codes
    // ------------------------------------------------------------------
    localparam logic [15:0] DIAG_IDLE     = 16'h0000;
    localparam logic [15:0] DIAG_SELECTED = 16'h8000;
    localparam logic [15:0] DIAG_CHANGED  = 16'h8005;
    localparam logic [15:0] DIAG_SHORT    = 16'hC001;
    localparam logic [15:0] DIAG_OPEN     = 16'hC002;
    localparam logic [15:0] DIAG_RST_ERR1 = 16'hC003;
    localparam logic [15:0] DIAG_RST_ERR2 = 16'hC004;

    typedef enum logic [2:0] {
        SMS_IDLE     = 3'b000,
        SMS_CHANGED  = 3'b001,
        SMS_SELECTED = 3'b010,
        SMS_SHORT    = 3'b011,
        SMS_OPEN     = 3'b100,
        SMS_RST_ERR1 = 3'b101,
        SMS_RST_ERR2 = 3'b110
    } sms_state_t;

    typedef struct packed {
        logic auto_confirm;
        logic activate;
    } sms_ctrl_t;

endpackage

// ===== rtl/sms_selector.sv
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps

// Operation
// - Eight exclusive mode request inputs, each with its own selected output.
// - Activation enters awaiting-selection state with all selection outputs low.
// - Without auto confirm, a request is selected only after a confirm rise.
// - With auto confirm, an active request is selected without confirm.
// - Leaving awaiting-selection needs an active request; a bare confirm does nothing.
// - No timeout while waiting for the operator confirm.
// - Request and unlock dropping together returns to awaiting-selection.
// - Unlock low freezes the selection; unlock high permits changes.
// - While locked, auto confirm is ignored.
// - Moving the switch clears all selection outputs before a new selection.
// - Manual selection latches on the confirm rising edge, not its level.
// - Any-selected is high only while exactly one mode is selected.
// - Sixteen-bit diagnostic code shows the state code, zero by default.
// - Activate low forces idle from any state with top priority.
// - All requests low beyond monitor time raises open-circuit error C002.
// - Several requests high raises short-circuit error C001 at once.
// - Any error clears selection outputs, shows its code and sets error.
// - Reset high on error entry is a reset error; reset rise clears errors.
module sms_selector
    import sms_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Operator pins
    input  wire logic [7:0]  mode_request,
    input  wire logic        unlock,
    input  wire logic        confirm_selection,
    input  wire logic        err_reset,
    // Machine side
    output logic [7:0]       mode_selected,
    output logic             any_mode_selected,
    output logic             error,
    output logic             ready,
    output logic [15:0]      diag_code_a
);
    import sms_pkg::*;

    // ------------------------------------------------------------------
    // Registers and synchronisers
    // ------------------------------------------------------------------
    sms_ctrl_t   ctrl_r;
    logic [15:0] mon_ms_r;
    logic [7:0]  req_m1, req_s, req_q, sel_r, sel_nxt;
    logic [2:0]  pin_m1, pin_s;
    logic        unlock_q, confirm_q, reset_q;
    sms_state_t  state_r, state_nxt;
    logic [16:0] cyc_cnt_r;
    logic [15:0] ms_cnt_r;
    logic        aw_have_r, w_have_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;

    // Operator pins are asynchronous; only the second stage and the third-stage copies are read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_m1 <= 8'h00;
            req_s  <= 8'h00;
            pin_m1 <= 3'h0;
            pin_s  <= 3'h0;
        end else begin
            req_m1 <= mode_request;
            req_s  <= req_m1;
            pin_m1 <= {err_reset, confirm_selection, unlock};
            pin_s  <= pin_m1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_q     <= 8'h00;
            unlock_q  <= 1'b0;
            confirm_q <= 1'b0;
            reset_q   <= 1'b0;
        end else begin
            req_q     <= req_s;
            unlock_q  <= pin_s[0];
            confirm_q <= pin_s[1];
            reset_q   <= pin_s[2];
        end
    end

    // ------------------------------------------------------------------
    // Input decoding
    // ------------------------------------------------------------------
    logic unlock_s, confirm_rise, reset_rise, none_req, multi_req, one_req;
    logic auto_eff, req_fall, open_err, sel_gone;
    assign unlock_s     = pin_s[0];
    assign confirm_rise = pin_s[1] & ~confirm_q;
    assign reset_rise   = pin_s[2] & ~reset_q;
    assign none_req     = (req_s == 8'h00);
    assign multi_req    = !none_req && !$onehot(req_s);
    assign one_req      = $onehot(req_s);
    assign auto_eff     = ctrl_r.auto_confirm & unlock_s;
    assign req_fall     = |(req_q & ~req_s);
    assign open_err     = none_req && (ms_cnt_r >= mon_ms_r);
    assign sel_gone     = !(|(req_s & sel_r));

    // ------------------------------------------------------------------
    // Switch monitor timer
    // ------------------------------------------------------------------
    // Counts whole ms with no request active; held at zero while idle so activation starts afresh
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_cnt_r <= 17'h00000;
            ms_cnt_r  <= 16'h0000;
        end else if (req_fall || !none_req || state_r == SMS_IDLE) begin
            cyc_cnt_r <= 17'h00000;
            ms_cnt_r  <= 16'h0000;
        end else if (cyc_cnt_r == 17'(CYC_PER_MS - 1)) begin
            cyc_cnt_r <= 17'h00000;
            if (ms_cnt_r != 16'hFFFF) begin
                ms_cnt_r <= ms_cnt_r + 16'h0001;
            end
        end else begin
            cyc_cnt_r <= cyc_cnt_r + 17'h00001;
        end
    end

    // ------------------------------------------------------------------
    // Selection state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        sel_nxt   = sel_r;
        case (state_r)
            SMS_IDLE: begin
                sel_nxt = 8'h00;
                if (ctrl_r.activate) begin
                    state_nxt = SMS_CHANGED;
                end
            end
            SMS_CHANGED, SMS_SELECTED: begin
                if (multi_req) begin
                    state_nxt = pin_s[2] ? SMS_RST_ERR1 : SMS_SHORT;
                end else if (open_err) begin
                    state_nxt = pin_s[2] ? SMS_RST_ERR2 : SMS_OPEN;
                end else if (state_r == SMS_CHANGED) begin
                    // Waits for the operator with no timeout
                    if (one_req && (auto_eff || confirm_rise)) begin
                        state_nxt = SMS_SELECTED;
                        sel_nxt   = req_s;
                    end
                end else if (sel_gone && (unlock_s || unlock_q)) begin
                    state_nxt = SMS_CHANGED;
                    sel_nxt   = 8'h00;
                end
            end
            SMS_SHORT, SMS_OPEN: begin
                if (reset_rise) begin
                    state_nxt = SMS_CHANGED;
                    sel_nxt   = 8'h00;
                end
            end
            // A reset already high must drop before its rise counts
            SMS_RST_ERR1: state_nxt = pin_s[2] ? SMS_RST_ERR1 : SMS_SHORT;
            SMS_RST_ERR2: state_nxt = pin_s[2] ? SMS_RST_ERR2 : SMS_OPEN;
            default: begin
                state_nxt = SMS_IDLE;
            end
        endcase
        if (!ctrl_r.activate) begin
            state_nxt = SMS_IDLE;
            sel_nxt   = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= SMS_IDLE;
            sel_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sel_r   <= sel_nxt;
        end
    end

    // Outputs follow the next state so they line up with state_r
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_selected     <= 8'h00;
            any_mode_selected <= 1'b0;
            error             <= 1'b0;
            ready             <= 1'b0;
            diag_code_a       <= DIAG_IDLE;
        end else begin
            mode_selected     <= (state_nxt == SMS_SELECTED) ? sel_nxt : 8'h00;
            any_mode_selected <= (state_nxt == SMS_SELECTED) && $onehot(sel_nxt);
            error             <= (state_nxt >= SMS_SHORT);
            ready             <= ctrl_r.activate;
            case (state_nxt)
                SMS_IDLE:     diag_code_a <= DIAG_IDLE;
                SMS_CHANGED:  diag_code_a <= DIAG_CHANGED;
                SMS_SELECTED: diag_code_a <= DIAG_SELECTED;
                SMS_SHORT:    diag_code_a <= DIAG_SHORT;
                SMS_OPEN:     diag_code_a <= DIAG_OPEN;
                SMS_RST_ERR1: diag_code_a <= DIAG_RST_ERR1;
                SMS_RST_ERR2: diag_code_a <= DIAG_RST_ERR2;
                default:      diag_code_a <= DIAG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic do_write;
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h00000000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Control bits steer the state machine; monitor time is read live
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r       <= '0;
            mon_ms_r     <= MON_MS_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                case (aw_addr_r)
                    ADDR_CTRL: begin
                        if (w_strb_r[0]) begin
                            ctrl_r.activate     <= w_data_r[CTRL_ACT_BIT];
                            ctrl_r.auto_confirm <= w_data_r[CTRL_AUTO_BIT];
                        end
                    end
                    ADDR_MON: begin
                        if (w_strb_r[0]) begin
                            mon_ms_r[7:0] <= w_data_r[7:0];
                        end
                        if (w_strb_r[1]) begin
                            mon_ms_r[15:8] <= w_data_r[15:8];
                        end
                    end
                    ADDR_STATUS: s_axi_bresp <= RESP_OKAY;
                    default:     s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= 32'h00000000;
                case (s_axi_araddr)
                    ADDR_CTRL: begin
                        s_axi_rdata[CTRL_ACT_BIT]  <= ctrl_r.activate;
                        s_axi_rdata[CTRL_AUTO_BIT] <= ctrl_r.auto_confirm;
                    end
                    ADDR_MON:    s_axi_rdata[15:0] <= mon_ms_r;
                    ADDR_STATUS: s_axi_rdata <= {mode_selected, 5'h00, any_mode_selected, ready, error,
                                                 diag_code_a};
                    default:     s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_idle_priority: assert property (!ctrl_r.activate |=> state_r == SMS_IDLE && diag_code_a == DIAG_IDLE)
        else $error("activate low did not force idle");
    a_short_error: assert property ((state_r == SMS_CHANGED || state_r == SMS_SELECTED) && multi_req
                                    && ctrl_r.activate |=> error && mode_selected == 8'h00
                                    && (diag_code_a == DIAG_SHORT || diag_code_a == DIAG_RST_ERR1))
        else $error("short circuit not flagged at once");
    a_open_error: assert property (state_r == SMS_CHANGED && open_err && ctrl_r.activate
                                   |=> error && (diag_code_a == DIAG_OPEN || diag_code_a == DIAG_RST_ERR2))
        else $error("open circuit not flagged");
    a_manual_edge: assert property (state_r == SMS_CHANGED && !auto_eff && !confirm_rise && !multi_req
                                    && !open_err && ctrl_r.activate |=> !any_mode_selected && state_r == SMS_CHANGED)
        else $error("selection accepted without confirm edge");
    a_auto_accept: assert property (state_r == SMS_CHANGED && auto_eff && one_req && !open_err
                                    && ctrl_r.activate |=> any_mode_selected && mode_selected == $past(req_s))
        else $error("auto confirm did not select");
    a_bare_confirm: assert property (state_r == SMS_CHANGED && none_req && !open_err && ctrl_r.activate
                                     |=> state_r == SMS_CHANGED && diag_code_a == DIAG_CHANGED)
        else $error("left awaiting state without request");
    a_lock_freeze: assert property (state_r == SMS_SELECTED && !unlock_s && !unlock_q && !multi_req
                                    && !open_err && ctrl_r.activate ##1 ctrl_r.activate |-> $stable(mode_selected))
        else $error("locked selection changed");
    a_any_onehot: assert property (any_mode_selected |-> $onehot(mode_selected) && !error)
        else $error("any selected without single mode");
    a_err_clear: assert property ((state_r == SMS_SHORT || state_r == SMS_OPEN) && reset_rise
                                  && ctrl_r.activate |=> state_r == SMS_CHANGED && !error)
        else $error("reset edge did not clear error");
    a_ready_act: assert property (ctrl_r.activate [*2] |-> ready)
        else $error("ready not following activate");

endmodule // sms_selector

// ===== verif/sms_operator.sv
`timescale 1ns/1ps
module sms_operator (
    // Clock
    input  wire logic clk,
    // Switch and buttons
    output logic [7:0] mode_request,
    output logic       unlock,
    output logic       confirm_selection,
    output logic       err_reset
);
    initial begin
        mode_request      = 8'h00;
        unlock            = 1'b1;
        confirm_selection = 1'b0;
        err_reset         = 1'b0;
    end
    // Break before make, so the knob never shorts two positions
    task automatic move(input logic [7:0] m, input int dwell);
        @(posedge clk) mode_request <= 8'h00;
        repeat (dwell) @(posedge clk);
        mode_request <= m;
    endtask
    task automatic press();
        @(posedge clk) confirm_selection <= 1'b0;
        repeat (3) @(posedge clk);
        confirm_selection <= 1'b1;
    endtask
    // Unlock, reset and switch in one scan: the only way a shorted switch is shown
    task automatic pins(input logic u, input logic r, input logic [7:0] m);
        @(posedge clk) unlock <= u;
        err_reset    <= r;
        mode_request <= m;
    endtask
endmodule // sms_operator

// ===== verif/tb_safety_mode_selector.sv
`timescale 1ns/1ps
module tb_safety_mode_selector;
    import sms_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0]  mode_request, mode_selected;
    logic        unlock, confirm_selection, err_reset, any_mode_selected, error, ready;
    logic [15:0] diag_code_a;
    int          err_count = 0, check_count = 0;
    always #10 clk = ~clk;
    // Short ms so the open-circuit timer fits the run
    sms_selector #(.CYC_PER_MS(10)) u_dut (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mode_request(mode_request),
        .unlock(unlock), .confirm_selection(confirm_selection), .err_reset(err_reset),
        .mode_selected(mode_selected), .any_mode_selected(any_mode_selected), .error(error),
        .ready(ready), .diag_code_a(diag_code_a));
    sms_operator u_op (.clk(clk), .mode_request(mode_request), .unlock(unlock),
                       .confirm_selection(confirm_selection), .err_reset(err_reset));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tmo();
        err_count++;
        $display("[ERR] %0t bus timeout", $time);
        results();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) tmo();
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) tmo();
    endtask
    task automatic scans(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Any-selected and error follow from the expected selection and code
    task automatic st(input logic [7:0] sel, input logic [15:0] dg);
        chk({mode_selected, any_mode_selected, error, diag_code_a}, {sel, |sel, dg[15:14] == 2'b11, dg}, "outputs");
    endtask
    task automatic t_regs();
        rdr(ADDR_CTRL, rd, rsp);
        chk(rd, 32'h0, "ctrl reset");
        rdr(ADDR_STATUS, rd, rsp);
        chk(rd, 32'h0, "status reset");
        rdr(8'h0C, rd, rsp);
        chk(rsp, RESP_SLVERR, "unmapped read");
        wr(8'h0C, 32'hFFFF_FFFF, rsp);
        chk(rsp, RESP_SLVERR, "unmapped write");
        wr(ADDR_MON, 32'h64, rsp);
        chk(rsp, RESP_OKAY, "write resp");
        rdr(ADDR_MON, rd, rsp);
        chk(rd, 32'h64, "monitor time");
        chk(rsp, RESP_OKAY, "read resp");
        $display("t_regs done");
    endtask
    task automatic t_manual();
        wr(ADDR_CTRL, 32'h1, rsp);
        scans(2);
        st(8'h00, DIAG_CHANGED);
        chk(ready, 1'b1, "ready");
        u_op.press();
        scans(5);
        st(8'h00, DIAG_CHANGED);
        for (int i = 0; i < 8; i++) begin
            // Confirm is still high here: its level must select nothing
            u_op.move(8'h01 << i, 3);
            scans(5);
            st(8'h00, DIAG_CHANGED);
            u_op.press();
            scans(5);
            st(8'h01 << i, DIAG_SELECTED);
        end
        $display("t_manual done");
    endtask
    task automatic t_lock();
        u_op.pins(1'b0, 1'b0, 8'h80);
        scans(4);
        u_op.move(8'h02, 3);
        u_op.press();
        scans(6);
        st(8'h80, DIAG_SELECTED);
        wr(ADDR_CTRL, 32'h3, rsp);
        scans(4);
        st(8'h80, DIAG_SELECTED);
        wr(ADDR_CTRL, 32'h0, rsp);
        scans(2);
        st(8'h00, DIAG_IDLE);
        chk(ready, 1'b0, "ready low");
        $display("t_lock done");
    endtask
    task automatic t_auto();
        u_op.pins(1'b1, 1'b0, 8'h02);
        wr(ADDR_CTRL, 32'h3, rsp);
        scans(3);
        u_op.move(8'h10, 3);
        scans(6);
        st(8'h10, DIAG_SELECTED);
        u_op.pins(1'b0, 1'b0, 8'h00);
        scans(5);
        st(8'h00, DIAG_CHANGED);
        // Locked while awaiting: a new request must not be taken automatically
        u_op.pins(1'b0, 1'b0, 8'h08);
        scans(5);
        st(8'h00, DIAG_CHANGED);
        $display("t_auto done");
    endtask
    task automatic t_err();
        wr(ADDR_CTRL, 32'h1, rsp);
        u_op.pins(1'b1, 1'b0, 8'h03);
        scans(5);
        st(8'h00, DIAG_SHORT);
        u_op.pins(1'b1, 1'b0, 8'h01);
        scans(3);
        u_op.pins(1'b1, 1'b1, 8'h01);
        scans(5);
        st(8'h00, DIAG_CHANGED);
        u_op.pins(1'b1, 1'b1, 8'h0C);
        scans(5);
        st(8'h00, DIAG_RST_ERR1);
        u_op.pins(1'b1, 1'b0, 8'h04);
        scans(4);
        st(8'h00, DIAG_SHORT);
        u_op.pins(1'b1, 1'b1, 8'h04);
        scans(4);
        st(8'h00, DIAG_CHANGED);
        wr(ADDR_MON, 32'h1, rsp);
        u_op.pins(1'b1, 1'b0, 8'h00);
        scans(5);
        st(8'h00, DIAG_CHANGED);
        scans(20);
        st(8'h00, DIAG_OPEN);
        rdr(ADDR_STATUS, rd, rsp);
        chk(rd, 32'h0003_C002, "status");
        $display("t_err done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_manual();
        t_lock();
        t_auto();
        t_err();
        results();
    end
endmodule // tb_safety_mode_selector
